// *** logic/smc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "smc_cfg.svh"
module smc_ctrl #(
	parameter int NUM_CS = `SMC_NUM_CS,
	parameter int ADDR_W = `SMC_ADDR_W,
	parameter int DATA_W = `SMC_DATA_W
) (
	input wire logic clk,
	input wire logic reset,
	// Request port
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [2:0] req_cs,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	input wire logic [3:0] req_be,
	input wire logic [5:0] req_burst_bytes,
	input wire logic boot_fetch,
	output logic req_ready,
	output logic rsp_valid,
	output logic rsp_error,
	output logic [DATA_W-1:0] rsp_rdata,
	// Per chip select width and access type; shared timing configuration
	input wire logic [2*NUM_CS-1:0] bus_width_field,
	input wire logic [NUM_CS-1:0] byte_access_type,
	input wire logic slow_clock_mode,
	input wire logic [3:0] cfg_setup,
	input wire logic [3:0] cfg_pulse,
	input wire logic [3:0] cfg_hold,
	// External pins
	output logic [NUM_CS-1:0] chip_select_n,
	output logic read_strobe_n,
	output logic pin_we_wr0_n,
	output logic pin_bs0_a0,
	output logic pin_bs1_wr1_n,
	output logic pin_bs2_wr2_a1,
	output logic pin_bs3_wr3_n,
	output logic [ADDR_W-1:2] addr_hi,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe,
	input wire logic [DATA_W-1:0] data_in,
	input wire logic ext_wait_n
);
	////////////////////////////////////////////////////////////////////////////
	// Parameter checks
	initial
	begin
		if (NUM_CS != 8 || ADDR_W != 26 || DATA_W != 32)
			$error("smc_ctrl geometry unsupported");
	end

	////////////////////////////////////////////////////////////////////////////
	// State
	smc_pkg::smc_state_t state_q; // Sequencer state
	logic [3:0] cnt_q; // Phase counter
	logic [3:0] t_setup_q; // Latched setup
	logic [3:0] t_pulse_q; // Latched pulse
	logic [3:0] t_hold_q; // Latched hold
	logic wr_q; // Access is write
	logic [2:0] cs_q; // Target chip select
	logic [ADDR_W-1:0] addr_q; // Current address
	logic [3:0] be_q; // Byte enables
	logic [5:0] left_q; // Burst bytes remaining
	smc_pkg::smc_dbw_t dbw_q; // Latched width
	logic bat_q; // Latched access type
	logic [DATA_W-1:0] cap_d; // Capture data
	logic cap_load; // Capture strobe
	logic pulse_end; // Last pulse cycle
	logic [5:0] step; // Bytes per beat

	// Width decode, used per chip select and per beat
	function automatic logic [5:0] beat_bytes(input smc_pkg::smc_dbw_t w);
		if (w == `SMC_DBW_32)
			return 6'h04;
		else if (w == `SMC_DBW_16)
			return 6'h02;
		else
			return 6'h01;
	endfunction

	// Selected configuration of the requesting chip select
	smc_pkg::smc_dbw_t req_dbw;
	logic req_bat;
	logic req_bad;
	assign req_dbw = bus_width_field[2*req_cs +: 2];
	assign req_bat = byte_access_type[req_cs] & (req_dbw != `SMC_DBW_8);
	assign req_bad = boot_fetch & req_bat;
	assign step = beat_bytes(dbw_q);
	assign pulse_end = (state_q == smc_pkg::SMC_PULSE) && (cnt_q <= 4'h1) && ext_wait_n;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_q <= smc_pkg::SMC_IDLE;
			cnt_q <= 4'h0;
			left_q <= 6'h00;
		end
		else
		begin
			unique case (state_q)
				smc_pkg::SMC_IDLE:
				begin
					// Start only a legal request
					if (req_valid && !req_bad)
					begin
						state_q <= smc_pkg::SMC_SETUP;
						cnt_q <= slow_clock_mode ? `SMC_SLOW_SETUP : cfg_setup;
						// Bursts are clamped to one page
						if (req_write || req_burst_bytes == 6'h00)
							left_q <= beat_bytes(req_dbw);
						else if (req_burst_bytes > `SMC_PAGE_MAX_BYTES)
							left_q <= `SMC_PAGE_MAX_BYTES;
						else
							left_q <= req_burst_bytes;
					end
				end
				smc_pkg::SMC_SETUP:
				begin
					// Setup then strobe pulse
					if (cnt_q <= 4'h1)
					begin
						state_q <= smc_pkg::SMC_PULSE;
						cnt_q <= t_pulse_q;
					end
					else
						cnt_q <= cnt_q - 4'h1;
				end
				smc_pkg::SMC_PULSE:
				begin
					// Wait low freezes the pulse
					if (pulse_end)
					begin
						if (!wr_q && left_q > step)
						begin
							// Next page beat reuses the strobe
							left_q <= left_q - step;
							cnt_q <= t_pulse_q;
						end
						else
						begin
							state_q <= smc_pkg::SMC_HOLD;
							cnt_q <= t_hold_q;
						end
					end
					else if (ext_wait_n && cnt_q > 4'h1)
						cnt_q <= cnt_q - 4'h1;
				end
				smc_pkg::SMC_HOLD:
				begin
					// Hold then release
					if (cnt_q <= 4'h1)
						state_q <= smc_pkg::SMC_IDLE;
					else
						cnt_q <= cnt_q - 4'h1;
				end
				default:
					state_q <= smc_pkg::SMC_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Access latch
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wr_q <= 1'b0;
			cs_q <= 3'h0;
			addr_q <= '0;
			be_q <= 4'h0;
			dbw_q <= `SMC_DBW_8;
			bat_q <= `SMC_BAT_SELECT;
			t_setup_q <= `SMC_DEF_SETUP;
			t_pulse_q <= `SMC_DEF_PULSE;
			t_hold_q <= `SMC_DEF_HOLD;
		end
		else if (state_q == smc_pkg::SMC_IDLE && req_valid && !req_bad)
		begin
			wr_q <= req_write;
			cs_q <= req_cs;
			addr_q <= req_addr;
			be_q <= req_be;
			dbw_q <= req_dbw;
			bat_q <= req_bat;
			t_setup_q <= slow_clock_mode ? `SMC_SLOW_SETUP : cfg_setup;
			t_pulse_q <= slow_clock_mode ? `SMC_SLOW_PULSE : ((cfg_pulse == 4'h0) ? 4'h1 : cfg_pulse);
			t_hold_q <= slow_clock_mode ? `SMC_SLOW_HOLD : cfg_hold;
		end
		else if (pulse_end && !wr_q && left_q > step)
			addr_q <= addr_q + ADDR_W'(step);
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin drive
	logic active;
	logic strobe;
	assign active = (state_q != smc_pkg::SMC_IDLE);
	assign strobe = (state_q == smc_pkg::SMC_PULSE);
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			chip_select_n <= '1;
			read_strobe_n <= 1'b1;
			pin_we_wr0_n <= 1'b1;
			pin_bs0_a0 <= 1'b1;
			pin_bs1_wr1_n <= 1'b1;
			pin_bs2_wr2_a1 <= 1'b1;
			pin_bs3_wr3_n <= 1'b1;
			addr_hi <= '0;
			data_out <= '0;
			data_oe <= 1'b0;
		end
		else
		begin
			// Active low chip select per region
			for (int i = 0; i < NUM_CS; i++)
				chip_select_n[i] <= !(active && cs_q == 3'(i));
			addr_hi <= addr_q[ADDR_W-1:2];
			read_strobe_n <= !(strobe && !wr_q);
			data_out <= req_wdata;
			data_oe <= active && wr_q;
			if (!active)
			begin
				pin_we_wr0_n <= 1'b1;
				pin_bs0_a0 <= 1'b1;
				pin_bs1_wr1_n <= 1'b1;
				pin_bs2_wr2_a1 <= 1'b1;
				pin_bs3_wr3_n <= 1'b1;
			end
			else if (dbw_q == `SMC_DBW_8)
			begin
				pin_bs0_a0 <= addr_q[0];
				pin_we_wr0_n <= !(strobe && wr_q);
				pin_bs1_wr1_n <= 1'b1;
				pin_bs2_wr2_a1 <= addr_q[1];
				pin_bs3_wr3_n <= 1'b1;
			end
			else if (bat_q == `SMC_BAT_WRITE)
			begin
				// Lane strobes; selects unused
				pin_bs0_a0 <= 1'b1;
				pin_we_wr0_n <= !(strobe && wr_q && be_q[0]);
				pin_bs1_wr1_n <= !(strobe && wr_q && be_q[1]);
				if (dbw_q == `SMC_DBW_32)
					pin_bs2_wr2_a1 <= !(strobe && wr_q && be_q[2]);
				else
					pin_bs2_wr2_a1 <= addr_q[1];
				pin_bs3_wr3_n <= !(strobe && wr_q && be_q[3] && dbw_q == `SMC_DBW_32);
			end
			else
			begin
				// Lane selects follow the address phase
				pin_we_wr0_n <= !(strobe && wr_q);
				pin_bs0_a0 <= !be_q[0];
				pin_bs1_wr1_n <= !be_q[1];
				if (dbw_q == `SMC_DBW_32)
					pin_bs2_wr2_a1 <= !be_q[2];
				else
					pin_bs2_wr2_a1 <= addr_q[1];
				pin_bs3_wr3_n <= !(be_q[3] && dbw_q == `SMC_DBW_32);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Request handshake and response
	assign cap_load = pulse_end && !wr_q;
	assign cap_d = data_in;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_error <= 1'b0;
		end
		else
		begin
			req_ready <= (state_q == smc_pkg::SMC_HOLD && cnt_q <= 4'h1);
			rsp_valid <= pulse_end || (state_q == smc_pkg::SMC_IDLE && req_valid && req_bad);
			rsp_error <= state_q == smc_pkg::SMC_IDLE && req_valid && req_bad;
		end
	end

	smc_rdata_reg #(
		.WIDTH(DATA_W)
	) u_rdata (
		.clk(clk),
		.reset(reset),
		.load(cap_load),
		.din(cap_d),
		.dout(rsp_rdata)
	);

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	idle_high_a: assert property (@(posedge clk) disable iff (reset)
		$past(state_q) == smc_pkg::SMC_IDLE && state_q == smc_pkg::SMC_IDLE |=> chip_select_n == '1)
		else $error("chip select asserted while idle");
	one_cs_a: assert property (@(posedge clk) disable iff (reset) $onehot0(~chip_select_n))
		else $error("more than one chip select low");
	wait_hold_a: assert property (@(posedge clk) disable iff (reset)
		strobe && !ext_wait_n |=> strobe)
		else $error("wait did not extend pulse");
	rd_strobe_a: assert property (@(posedge clk) disable iff (reset)
		strobe && !wr_q |=> !read_strobe_n)
		else $error("read strobe not low");
	bw_sel_a: assert property (@(posedge clk) disable iff (reset)
		active && bat_q && dbw_q != `SMC_DBW_8 |=> pin_bs0_a0)
		else $error("lane select used in byte write");
	boot_bw_a: assert property (@(posedge clk) disable iff (reset)
		state_q == smc_pkg::SMC_IDLE && req_valid && req_bad |=> state_q == smc_pkg::SMC_IDLE && rsp_error)
		else $error("boot from byte write started");
	a0_map_a: assert property (@(posedge clk) disable iff (reset)
		active && dbw_q == `SMC_DBW_8 |=> pin_bs0_a0 == $past(addr_q[0]))
		else $error("a0 not on lane 0 pin");
	page_max_a: assert property (@(posedge clk) disable iff (reset)
		left_q <= `SMC_PAGE_MAX_BYTES)
		else $error("burst exceeds page");
	slow_pulse_a: assert property (@(posedge clk) disable iff (reset)
		state_q == smc_pkg::SMC_IDLE && req_valid && !req_bad && slow_clock_mode
		|=> t_pulse_q == `SMC_SLOW_PULSE)
		else $error("slow waveform not applied");
	read_c: cover property (@(posedge clk) disable iff (reset) cap_load);
	write_c: cover property (@(posedge clk) disable iff (reset) strobe && wr_q && bat_q);
	wait_c: cover property (@(posedge clk) disable iff (reset) strobe && !ext_wait_n);
	burst_c: cover property (@(posedge clk) disable iff (reset) pulse_end && left_q > step);
endmodule // smc_ctrl
`default_nettype wire

// *** logic/smc_cfg.svh ***
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH
// Chip select count and bus widths
`define SMC_NUM_CS 8
`define SMC_ADDR_W 26
`define SMC_DATA_W 32
// Width field encodings
`define SMC_DBW_8 2'h0
`define SMC_DBW_16 2'h1
`define SMC_DBW_32 2'h2
// Byte access type encodings
`define SMC_BAT_SELECT 1'h0
`define SMC_BAT_WRITE 1'h1
// Default strobe timing in cycles
`define SMC_DEF_SETUP 4'h1
`define SMC_DEF_PULSE 4'h2
`define SMC_DEF_HOLD 4'h1
// Fixed slow clock mode timing in cycles
`define SMC_SLOW_SETUP 4'h2
`define SMC_SLOW_PULSE 4'h8
`define SMC_SLOW_HOLD 4'h2
// Largest page burst in bytes
`define SMC_PAGE_MAX_BYTES 6'h20
`endif

// *** logic/smc_pkg.sv ***
`include "smc_cfg.svh"
package smc_pkg;
	// Access sequencer states
	typedef enum logic [2:0] {SMC_IDLE, SMC_SETUP, SMC_PULSE, SMC_HOLD} smc_state_t;
	// Data width selection
	typedef logic [1:0] smc_dbw_t;
endpackage

// *** logic/smc_rdata_reg.sv ***
`timescale 1ns/1ps
`default_nettype none
// Read data capture register
module smc_rdata_reg #(
	parameter int WIDTH = 32
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic load,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	// Captures bus data at the end of a read pulse
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			dout <= '0;
		else if (load)
			dout <= din;
	end
endmodule // smc_rdata_reg
`default_nettype wire

// *** test/smc_sram_model.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// 32-bit byte-select SRAM that can stretch accesses
module smc_sram_model (
	input wire logic clk,
	input wire logic [7:0] chip_select_n,
	input wire logic read_strobe_n,
	input wire logic we_n,
	input wire logic [3:0] lane_n,
	input wire logic [25:2] addr_hi,
	input wire logic [31:0] data_out,
	input wire logic [3:0] stall,
	output logic [31:0] data_in,
	output logic ext_wait_n
);
	logic [31:0] mem [0:63]; // Word store
	logic [3:0] wait_q = 4'h0; // Stretch cycles left
	logic strobe_q = 1'b0; // Strobe seen last cycle
	wire logic sel = (chip_select_n != 8'hff);
	wire logic strobe = sel && (!read_strobe_n || !we_n);
	// Falling strobe starts a stretch
	always @(posedge clk)
	begin
		strobe_q <= strobe;
		if (strobe && !strobe_q && stall != 4'h0)
			wait_q <= stall;
		else if (wait_q != 4'h0)
			wait_q <= wait_q - 4'h1;
	end
	// Wait drops as soon as the strobe falls, like a real slow device
	assign ext_wait_n = !((strobe && !strobe_q && stall != 4'h0) || wait_q != 4'h0);
	// Read data follows the strobe at once; released bus shows the inverse
	assign data_in = (sel && !read_strobe_n) ? mem[addr_hi[7:2]] : ~mem[addr_hi[7:2]];
	// Byte lanes written while the write strobe is low
	always @(posedge clk)
	begin
		if (sel && !we_n)
			for (int i = 0; i < 4; i++)
				if (!lane_n[i])
					mem[addr_hi[7:2]][8*i +: 8] <= data_out[8*i +: 8];
	end
endmodule // smc_sram_model
`default_nettype wire

// *** test/static_memory_bus_mapping_test.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
module static_memory_bus_mapping_test;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic req_valid = 0, req_write = 0, boot_fetch = 0, slow_clock_mode = 0;
	logic [2:0] req_cs = 0;
	logic [25:0] req_addr = 0;
	logic [31:0] req_wdata = 0, rsp_rdata, data_out, data_in;
	logic [3:0] req_be = 0, stall = 0, lane_and;
	logic [5:0] req_burst_bytes = 0;
	logic req_ready, rsp_valid, rsp_error, read_strobe_n, pin_we_wr0_n, data_oe, ext_wait_n;
	logic pin_bs0_a0, pin_bs1_wr1_n, pin_bs2_wr2_a1, pin_bs3_wr3_n, rd_and, we_and, err, oe_or;
	logic [7:0] chip_select_n, cs_and;
	logic [25:2] addr_hi, addr_s;
	int rd_cnt, beats, fail_count, num_checks;
	always #12.5 clk = ~clk;
	// cs0 16 sel, cs1 8, cs2 32 sel, cs3 32 write, cs4 16 write
	smc_ctrl u_smc_ctrl (.clk, .reset, .req_valid, .req_write, .req_cs, .req_addr,
		.req_wdata, .req_be, .req_burst_bytes, .boot_fetch, .req_ready, .rsp_valid,
		.rsp_error, .rsp_rdata, .bus_width_field(16'h01a1), .byte_access_type(8'h18),
		.slow_clock_mode, .cfg_setup(4'h1), .cfg_pulse(4'h2), .cfg_hold(4'h1),
		.chip_select_n, .read_strobe_n, .pin_we_wr0_n, .pin_bs0_a0, .pin_bs1_wr1_n,
		.pin_bs2_wr2_a1, .pin_bs3_wr3_n, .addr_hi, .data_out, .data_oe, .data_in, .ext_wait_n);
	smc_sram_model u_smc_sram_model (.clk, .chip_select_n, .read_strobe_n,
		.we_n(pin_we_wr0_n), .lane_n({pin_bs3_wr3_n, pin_bs2_wr2_a1, pin_bs1_wr1_n, pin_bs0_a0}),
		.addr_hi, .data_out, .stall, .data_in, .ext_wait_n);
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			fail_count++;
		end
	endtask
	// One access; pins folded while selected
	task automatic acc(input logic wr, input logic [2:0] cs, input logic [25:0] a,
		input logic [31:0] d, input logic [3:0] be, input logic [5:0] bb, input logic boot);
		int n;
		n = 0;
		{req_valid, req_write, req_cs, req_addr, req_wdata} = {1'b1, wr, cs, a, d};
		{req_be, req_burst_bytes, boot_fetch} = {be, bb, boot};
		cs_and = 8'hff;
		rd_and = 1'b1;
		we_and = 1'b1;
		lane_and = 4'hf;
		err = 1'b0;
		oe_or = 1'b0;
		rd_cnt = 0;
		beats = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
			if (chip_select_n != 8'hff)
			begin
				cs_and &= chip_select_n;
				rd_and &= read_strobe_n;
				we_and &= pin_we_wr0_n;
				lane_and &= {pin_bs3_wr3_n, pin_bs2_wr2_a1, pin_bs1_wr1_n, pin_bs0_a0};
				addr_s = addr_hi;
				oe_or |= data_oe;
			end
			rd_cnt += int'(read_strobe_n === 1'b0);
			beats += int'(rsp_valid === 1'b1);
			err |= (rsp_error === 1'b1);
		end
		while (req_ready !== 1'b1 && !err && n < 300);
		req_valid = 1'b0;
		boot_fetch = 1'b0;
		chk("bounded wait", 1, n < 300);
		repeat (2) @(posedge clk);
		#1;
		chk("idle pins", 32'h1fff, 32'({chip_select_n, read_strobe_n, pin_we_wr0_n,
			pin_bs1_wr1_n, pin_bs3_wr3_n, pin_bs0_a0}));
	endtask
	task automatic t_8bit;
		acc(0, 3'h1, 26'h3abcd65, 0, 4'h1, 0, 0);
		chk("cs", 8'hfd, cs_and);
		chk("a0 pin", 1, lane_and[0]);
		chk("a1 pin", 0, lane_and[2]);
		chk("addr", 24'heaf359, addr_s);
		chk("rd", 0, rd_and);
		acc(0, 3'h1, 26'h0000006, 0, 4'h1, 0, 0);
		chk("a0 pin", 0, lane_and[0]);
		chk("a1 pin", 1, lane_and[2]);
		$display("test 8bit done");
	endtask
	task automatic t_bsel;
		acc(1, 3'h2, 26'h10, 32'hc3a55a3c, 4'hf, 0, 0);
		chk("lanes", 4'h0, lane_and);
		chk("we", 0, we_and);
		chk("oe", 1, oe_or);
		acc(1, 3'h2, 26'h10, 32'h11223344, 4'h5, 0, 0);
		chk("lanes", 4'ha, lane_and);
		chk("rd", 1, rd_and);
		acc(0, 3'h2, 26'h10, 0, 4'hc, 0, 0);
		chk("lanes", 4'h3, lane_and);
		chk("we", 1, we_and);
		chk("oe", 0, oe_or);
		chk("rdata", 32'hc3225a44, rsp_rdata);
		chk("pulse", 2, rd_cnt);
		$display("test byte select done");
	endtask
	task automatic t_bwr;
		acc(1, 3'h3, 26'h40, 0, 4'ha, 0, 0);
		chk("strobes", 4'h5, {lane_and[3:1], we_and});
		chk("rd", 1, rd_and);
		acc(0, 3'h3, 26'h40, 0, 4'hf, 0, 0);
		chk("strobes", 4'hf, {lane_and[3:1], we_and});
		chk("rd", 0, rd_and);
		acc(1, 3'h4, 26'h0, 0, 4'h1, 0, 0);
		chk("strobes", 2'h2, {lane_and[1], we_and});
		chk("a1 pin", 0, lane_and[2]);
		acc(0, 3'h0, 26'h2, 0, 4'hf, 0, 0);
		chk("a1 pin", 1, lane_and[2]);
		chk("cs", 8'hfe, cs_and);
		$display("test byte write done");
	endtask
	task automatic t_misc;
		acc(0, 3'h4, 26'h0, 0, 4'hf, 0, 1);
		chk("refused", 1, err);
		chk("cs", 8'hff, cs_and);
		acc(0, 3'h0, 26'h0, 0, 4'hf, 0, 1);
		chk("refused", 0, err);
		stall = 4'h3;
		acc(0, 3'h2, 26'h10, 0, 4'hf, 0, 0);
		chk("stretched", 1, rd_cnt >= 4);
		stall = 4'h0;
		slow_clock_mode = 1'b1;
		acc(0, 3'h2, 26'h10, 0, 4'hf, 0, 0);
		chk("slow pulse", 8, rd_cnt);
		slow_clock_mode = 1'b0;
		acc(0, 3'h2, 26'h10, 0, 4'hf, 6'h08, 0);
		chk("beats", 2, beats);
		acc(0, 3'h2, 26'h10, 0, 4'hf, 6'h3f, 0);
		chk("beats", 8, beats);
		$display("test refusal wait burst done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Watchdog well past the expected run
	initial
	begin
		#(25 * 20000);
		chk("watchdog", 1, 0);
		tally_and_finish();
	end
	initial
	begin
		repeat (8) @(posedge clk);
		#1 reset = 1'b0;
		chk("reset pins", 32'h1fff, 32'({chip_select_n, read_strobe_n, pin_we_wr0_n,
			pin_bs1_wr1_n, pin_bs3_wr3_n, pin_bs0_a0}));
		t_8bit();
		t_bsel();
		t_bwr();
		t_misc();
		tally_and_finish();
	end
endmodule // static_memory_bus_mapping_test
`default_nettype wire
